//--- rtl/ced_pkg.sv
package ced_pkg;

  // ****************************************
  // Register map (word index, byte = 4 * index)
  // ****************************************
  localparam logic [11:0] CSR_INDEX = 12'h097;
  localparam logic [11:0] CFG_INDEX = 12'h098;
  localparam logic [11:0] IST_INDEX = 12'h099;
  localparam logic [11:0] IMK_INDEX = 12'h09A;
  localparam logic [11:0] CSR_ADDR = 12'h25C;
  localparam logic [11:0] CFG_ADDR = 12'h260;
  localparam logic [11:0] IST_ADDR = 12'h264;
  localparam logic [11:0] IMK_ADDR = 12'h268;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CSR_FLAG_BIT = 4;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic IST_RESET = 1'b0;
  localparam logic IMK_RESET = 1'b0;

  // ****************************************
  // Event conditions
  // ****************************************
  localparam logic [2:0] CM_LOW = 3'h0;
  localparam logic [2:0] CM_RISE = 3'h1;
  localparam logic [2:0] CM_DB_TOGGLE = 3'h2;
  localparam logic [2:0] CM_DB_RISE = 3'h3;
  localparam logic [2:0] CM_FALL = 3'h4;
  localparam logic [2:0] CM_TOGGLE = 3'h5;
  localparam logic [2:0] CM_DB_FALL = 3'h6;
  localparam logic [2:0] CM_HIGH = 3'h7;

  // ****************************************
  // Sample clock choices and counts
  // ****************************************
  localparam logic [1:0] SCS_SYSCLK = 2'h0;
  localparam logic [1:0] SCS_TIMER0 = 2'h1;
  localparam logic [1:0] SCS_TIMER1 = 2'h2;
  localparam logic [1:0] SCS_TIMER2 = 2'h3;
  localparam logic [2:0] HOLD_SYSCLK = 3'h1;
  localparam logic [2:0] HOLD_TIMER = 3'h4;

  // Control and status layout, msb first
  typedef struct packed {
    logic [1:0] positive_channel_select;
    logic input_connect;
    logic event_flag;
    logic comparator_enable;
    logic [2:0] event_condition_select;
  } ced_csr_s;

  // Debounce sequencer, Gray along the wait path
  typedef enum logic [1:0] {
    DB_IDLE = 2'h0,
    DB_WAIT_FIRST = 2'h1,
    DB_WAIT_SECOND = 2'h3
  } ced_db_e;

endpackage : ced_pkg

//--- rtl/ced_sync2.sv
`timescale 1ns/100ps
module ced_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out
  input wire logic d,
  output logic q
);

  logic stage1;

  // Two-flop crossing; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule : ced_sync2

//--- rtl/ced_top.sv
`timescale 1ns/100ps
// Overview of operation
// - Default sampling takes the comparator output every clock cycle.
// - Debounced modes with sample select 00 pace on timer 1 overflows.
// - After a relevant transition, wait two pacing overflows before resampling.
// - Flag set only if resample matches expected level, else event dropped.
// - Free-running timer gives flag one to two periods after the edge.
// - Timer-paced sampling accepts an edge only after 4 consecutive samples.
// - Input connect bit one connects analog inputs, zero disconnects them.
// - Hardware sets event flag on condition; software clears; interrupt gated.
// - Disabled comparator forces output low and blocks new events.
// - Enabled comparator puts the four analog pins into input-only mode.
// - Condition field selects level, edge, toggle and debounced variants.
// - Two-bit sample select picks system clock or timer 0, 1, 2.
// - Comparator output is one when positive input exceeds negative.
module ced_top
  import ced_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparator side
  input wire logic comp_raw,
  output logic input_connect,
  output logic [1:0] positive_channel_select,
  output logic [3:0] pin_input_only,
  output logic comparator_out,
  // Timer overflow pulses, same clock
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  // Interrupt
  output logic irq
);

  // ****************************************
  // Reset release and input crossing
  // ****************************************
  logic rst_n;
  logic comp_sync;

  // Reset enters asynchronously, leaves through two flops
  ced_sync2 #(
    .RST_VAL(1'b0)
  ) u_rst_sync (
    .clk(ref_clk),
    .rst_n(arst_n),
    .d(1'b1),
    .q(rst_n)
  );

  ced_sync2 #(
    .RST_VAL(1'b0)
  ) u_comp_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(comp_raw),
    .q(comp_sync)
  );

  // ****************************************
  // Registers
  // ****************************************
  ced_csr_s csr;
  logic [1:0] sample_clock_select;
  logic ist_event;
  logic imk_event;
  logic event_hit;

  logic wr_en;
  logic rd_setup;
  logic rd_access;
  logic addr_hit;

  // APB phases; zero wait states
  assign wr_en = psel && penable && pwrite && addr_hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_hit;

  // Decode of the four word addresses
  always_comb
  begin
    case (paddr)
      CSR_ADDR: addr_hit = 1'b1;
      CFG_ADDR: addr_hit = 1'b1;
      IST_ADDR: addr_hit = 1'b1;
      IMK_ADDR: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Control fields and flag; one process, as the packed register allows one writer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      csr.positive_channel_select <= CSR_RESET[7:6];
      csr.input_connect <= CSR_RESET[5];
      csr.event_flag <= CSR_RESET[CSR_FLAG_BIT];
      csr.comparator_enable <= CSR_RESET[3];
      csr.event_condition_select <= CSR_RESET[2:0];
    end
    else
    begin
      if (wr_en && paddr == CSR_ADDR)
      begin
        // Channel changes taken as written; software disconnects first
        csr.positive_channel_select <= pwdata[7:6];
        csr.input_connect <= pwdata[5];
        csr.comparator_enable <= pwdata[3];
        csr.event_condition_select <= pwdata[2:0];
      end
      // flag set by event, cleared by writing zero
      if (event_hit)
      begin
        // A coincident clear loses to a new event
        csr.event_flag <= 1'b1;
      end
      else if (wr_en && paddr == CSR_ADDR && !pwdata[CSR_FLAG_BIT])
      begin
        csr.event_flag <= 1'b0;
      end
    end
  end

  // Sample clock selection
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sample_clock_select <= CFG_RESET;
    end
    else if (wr_en && paddr == CFG_ADDR)
    begin
      sample_clock_select <= pwdata[1:0];
    end
  end

  // Sticky status, cleared by a read access
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ist_event <= IST_RESET;
    end
    else if (event_hit)
    begin
      ist_event <= 1'b1;
    end
    else if (rd_access && paddr == IST_ADDR && prdata[0])
    begin
      // Clear only what the read reported; an event at the setup edge survives
      ist_event <= 1'b0;
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      imk_event <= IMK_RESET;
    end
    else if (wr_en && paddr == IMK_ADDR)
    begin
      imk_event <= pwdata[0];
    end
  end

  // Read data captured in setup, valid through access
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      case (paddr)
        CSR_ADDR: prdata <= {24'h00_0000, csr};
        CFG_ADDR: prdata <= {30'h0000_0000, sample_clock_select};
        IST_ADDR: prdata <= {31'h0000_0000, ist_event};
        IMK_ADDR: prdata <= {31'h0000_0000, imk_event};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign irq = ist_event && imk_event;

  // ****************************************
  // Pin side outputs
  // ****************************************
  logic active;
  logic comp_level;

  // connect bit drives the input mux
  assign input_connect = csr.input_connect;
  assign positive_channel_select = csr.positive_channel_select;
  assign pin_input_only = {4{csr.comparator_enable}};

  assign comp_level = csr.comparator_enable && comp_sync;
  assign active = csr.comparator_enable && csr.input_connect;

  // Registered copy for the pin
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comparator_out <= 1'b0;
    end
    else
    begin
      comparator_out <= comp_level;
    end
  end

  // ****************************************
  // Sampling and edge acceptance
  // ****************************************
  logic sample_stb;
  logic pace_stb;
  logic [2:0] hold_need;
  logic [2:0] hold_cnt;
  logic stable;
  logic edge_ok;
  logic edge_rise;
  logic edge_fall;
  logic [2:0] cond;
  logic debounced;

  assign cond = csr.event_condition_select;
  assign debounced = (cond == CM_DB_TOGGLE) || (cond == CM_DB_RISE) || (cond == CM_DB_FALL);

  // every clock by default; timer choices
  always_comb
  begin
    case (sample_clock_select)
      SCS_SYSCLK: sample_stb = 1'b1;
      SCS_TIMER0: sample_stb = timer0_ovf;
      SCS_TIMER1: sample_stb = timer1_ovf;
      SCS_TIMER2: sample_stb = timer2_ovf;
      default: sample_stb = 1'b1;
    endcase
  end

  // timer 1 paces the debounce wait under system clock sampling; otherwise the selected sample timer does
  assign pace_stb = (sample_clock_select == SCS_SYSCLK) ? timer1_ovf : sample_stb;

  // timer sampling needs four agreeing samples
  assign hold_need = (sample_clock_select == SCS_SYSCLK) ? HOLD_SYSCLK : HOLD_TIMER;
  assign edge_ok = active && sample_stb && (comp_level != stable) &&
                   ((hold_cnt + 3'h1) >= hold_need);
  assign edge_rise = edge_ok && comp_level;
  assign edge_fall = edge_ok && !comp_level;

  // Filtered level and run-length of disagreeing samples
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stable <= 1'b0;
      hold_cnt <= 3'h0;
    end
    else if (!active)
    begin
      stable <= 1'b0;
      hold_cnt <= 3'h0;
    end
    else if (sample_stb)
    begin
      if (comp_level == stable)
      begin
        hold_cnt <= 3'h0;
      end
      else if (edge_ok)
      begin
        stable <= comp_level;
        hold_cnt <= 3'h0;
      end
      else
      begin
        hold_cnt <= hold_cnt + 3'h1;
      end
    end
  end

  // ****************************************
  // Debounce sequencer
  // ****************************************
  ced_db_e db_state;
  ced_db_e next_db_state;
  logic expect_level;
  logic db_start;
  logic db_done;

  // Relevant transition for the chosen debounced mode
  always_comb
  begin
    case (cond)
      CM_DB_TOGGLE: db_start = edge_ok;
      CM_DB_RISE: db_start = edge_rise;
      CM_DB_FALL: db_start = edge_fall;
      default: db_start = 1'b0;
    endcase
  end

  // two pacing overflows before resample; free timer
  always_comb
  begin
    next_db_state = db_state;
    db_done = 1'b0;
    case (db_state)
      DB_IDLE:
      begin
        if (db_start)
        begin
          next_db_state = DB_WAIT_FIRST;
        end
      end
      DB_WAIT_FIRST:
      begin
        if (pace_stb)
        begin
          next_db_state = DB_WAIT_SECOND;
        end
      end
      DB_WAIT_SECOND:
      begin
        if (pace_stb)
        begin
          next_db_state = DB_IDLE;
          db_done = 1'b1;
        end
      end
      default: next_db_state = DB_IDLE;
    endcase
  end

  // State and the level the resample must show
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      db_state <= DB_IDLE;
      expect_level <= 1'b0;
    end
    else if (!active || !debounced)
    begin
      // wait abandoned on disable, disconnect or change to a non-debounced mode
      db_state <= DB_IDLE;
      expect_level <= 1'b0;
    end
    else
    begin
      db_state <= next_db_state;
      if (db_state == DB_IDLE && db_start)
      begin
        expect_level <= comp_level;
      end
    end
  end

  // ****************************************
  // Event decision
  // ****************************************
  // condition decode; resample must agree
  always_comb
  begin
    case (cond)
      CM_LOW: event_hit = sample_stb && !comp_level;
      CM_RISE: event_hit = edge_rise;
      CM_FALL: event_hit = edge_fall;
      CM_TOGGLE: event_hit = edge_ok;
      CM_HIGH: event_hit = sample_stb && comp_level;
      CM_DB_TOGGLE: event_hit = db_done && (comp_level == expect_level);
      CM_DB_RISE: event_hit = db_done && (comp_level == expect_level);
      CM_DB_FALL: event_hit = db_done && (comp_level == expect_level);
      default: event_hit = 1'b0;
    endcase
    // no events while disabled or disconnected
    if (!active)
    begin
      event_hit = 1'b0;
    end
  end

endmodule : ced_top

//--- tb/ced_checker.sv
`timescale 1ns/100ps
// ****************************************
// Port checks of the event block
// ****************************************
module ced_checker
  import ced_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Comparator side
  input wire logic comp_raw,
  input wire logic input_connect,
  input wire logic [1:0] positive_channel_select,
  input wire logic [3:0] pin_input_only,
  input wire logic comparator_out,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // Control write strobe, shared by several checks
  logic csr_wr;
  assign csr_wr = psel && penable && pwrite && (paddr == CSR_ADDR);

  a_connect_write: assert property (csr_wr |=> input_connect == $past(pwdata[5]))
    else $error("connect bit differs from written value");
  a_channel_write: assert property (csr_wr |=> positive_channel_select == $past(pwdata[7:6]))
    else $error("channel select differs from written value");
  a_pins_follow: assert property (csr_wr |=> pin_input_only == {4{$past(pwdata[3])}})
    else $error("input-only pins differ from enable bit");
  a_out_gated: assert property (comparator_out |-> $past(pin_input_only[0]))
    else $error("output high while disabled");
  // Three edges from pin to output: two sync flops and the output flop
  a_out_follow: assert property ($past(pin_input_only[0]) |-> comparator_out == $past(comp_raw, 3))
    else $error("output does not follow comparator");
  a_irq_cause: assert property ($rose(irq) |-> $past(pin_input_only[0] && input_connect)
    || $past(psel && penable && pwrite && paddr == IMK_ADDR))
    else $error("interrupt rose without cause");
  a_irq_sticky: assert property (irq && !(psel && (paddr == IST_ADDR || paddr == IMK_ADDR))
    |=> irq)
    else $error("interrupt dropped without software");
  a_ready_access: assert property (psel && penable |-> pready)
    else $error("access not answered");

  // Main scenarios reached
  c_irq: cover property ($rose(irq));
  c_out: cover property ($rose(comparator_out));
  c_err: cover property (psel && penable && pslverr);
endmodule : ced_checker

bind ced_top ced_checker u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .comp_raw(comp_raw), .input_connect(input_connect),
  .positive_channel_select(positive_channel_select), .pin_input_only(pin_input_only),
  .comparator_out(comparator_out), .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf),
  .timer2_ovf(timer2_ovf), .irq(irq));

//--- tb/test_comparator_event_debounce.sv
`timescale 1ns/100ps
module test_comparator_event_debounce
  import ced_pkg::*;
;
;
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, comp_raw;
  logic input_connect, comparator_out, irq, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [1:0] positive_channel_select;
  logic [3:0] pin_input_only;
  logic [2:0] tmr;
  int err_total = 0;
  int cmp_count = 0;
  // Expected status per phase, one bit per condition code
  logic [7:0] phase_exp [5] = '{8'h01, 8'hA3, 8'h8C, 8'hB1, 8'h45};

  ced_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comp_raw(comp_raw), .input_connect(input_connect),
    .positive_channel_select(positive_channel_select), .pin_input_only(pin_input_only),
    .comparator_out(comparator_out), .timer0_ovf(tmr[0]), .timer1_ovf(tmr[1]),
    .timer2_ovf(tmr[2]), .irq(irq));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Zero-wait slave, but the wait is still open-ended
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do
      @(posedge ref_clk);
    while (pready !== 1'h1);
    rd_data = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd_data, exp);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic set_comp(input logic v);
    @(posedge ref_clk);
    comp_raw <= v;
  endtask : set_comp

  task automatic pulse(input int b);
    @(posedge ref_clk);
    tmr[b] <= 1'h1;
    @(posedge ref_clk);
    tmr <= 3'h0;
  endtask : pulse

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset;
    chk({irq, comparator_out, pin_input_only}, 6'h00);
    rd(CSR_ADDR, 32'h0);
    rd(CFG_ADDR, 32'h0);
    rd(IST_ADDR, 32'h0);
    rd(IMK_ADDR, 32'h0);
    rd(12'h004, 32'h0);
    chk(last_err, 1'h1);
    $display("reset test done");
  endtask : test_reset

  task automatic test_rise;
    apb(1'h1, IMK_ADDR, 32'h1);
    apb(1'h1, CSR_ADDR, 32'h29);
    tick(1);
    chk({input_connect, pin_input_only}, 5'h1F);
    set_comp(1'h1);
    tick(3);
    chk(irq, 1'h0);
    tick(1);
    chk(irq, 1'h1);
    chk(comparator_out, 1'h1);
    rd(CSR_ADDR, 32'h39);
    rd(IST_ADDR, 32'h1);
    rd(IST_ADDR, 32'h0);
    apb(1'h1, CSR_ADDR, 32'h29);
    rd(CSR_ADDR, 32'h29);
    $display("rise test done");
  endtask : test_rise

  // Every condition code through low, rise, wait, fall, wait
  task automatic test_modes;
    for (int c = 0; c < 8; c++)
    begin
      apb(1'h1, CSR_ADDR, 32'h0);
      set_comp(1'h0);
      apb(1'h0, IST_ADDR, 32'h0);
      apb(1'h1, CSR_ADDR, 32'h28 | c);
      tick(8);
      rd(IST_ADDR, phase_exp[0][c]);
      set_comp(1'h1);
      tick(8);
      rd(IST_ADDR, phase_exp[1][c]);
      pulse(1);
      pulse(1);
      rd(IST_ADDR, phase_exp[2][c]);
      set_comp(1'h0);
      tick(8);
      rd(IST_ADDR, phase_exp[3][c]);
      pulse(1);
      pulse(1);
      rd(IST_ADDR, phase_exp[4][c]);
    end
    $display("modes test done");
  endtask : test_modes

  // Timer-paced rise needs four strobes of the chosen timer only
  task automatic test_timer;
    for (int s = 1; s < 4; s++)
    begin
      apb(1'h1, CSR_ADDR, 32'h0);
      set_comp(1'h0);
      apb(1'h1, CFG_ADDR, s);
      rd(CFG_ADDR, s);
      apb(1'h1, CSR_ADDR, 32'h29);
      set_comp(1'h1);
      tick(4);
      apb(1'h0, IST_ADDR, 32'h0);
      repeat (4) pulse(s % 3);
      repeat (3) pulse(s - 1);
      rd(IST_ADDR, 32'h0);
      pulse(s - 1);
      rd(IST_ADDR, 32'h1);
    end
    apb(1'h1, CFG_ADDR, 32'h0);
    $display("timer test done");
  endtask : test_timer

  task automatic test_discard;
    apb(1'h1, CSR_ADDR, 32'h0);
    set_comp(1'h0);
    apb(1'h1, CSR_ADDR, 32'h2B);
    apb(1'h0, IST_ADDR, 32'h0);
    set_comp(1'h1);
    tick(6);
    set_comp(1'h0);
    pulse(1);
    pulse(1);
    rd(IST_ADDR, 32'h0);
    set_comp(1'h1);
    tick(6);
    apb(1'h1, CSR_ADDR, 32'h0B);
    pulse(1);
    pulse(1);
    rd(IST_ADDR, 32'h0);
    $display("discard test done");
  endtask : test_discard

  task automatic test_irq;
    apb(1'h1, IMK_ADDR, 32'h0);
    apb(1'h1, CSR_ADDR, 32'hEF);
    tick(6);
    chk(irq, 1'h0);
    rd(CSR_ADDR, 32'hFF);
    apb(1'h1, IMK_ADDR, 32'h1);
    tick(2);
    chk({irq, positive_channel_select}, 3'h7);
    apb(1'h1, CSR_ADDR, 32'h27);
    tick(2);
    chk({comparator_out, pin_input_only}, 5'h00);
    apb(1'h0, IST_ADDR, 32'h0);
    tick(4);
    rd(IST_ADDR, 32'h0);
    // Disabling edge still carried an event, so the flag is cleared again here
    apb(1'h1, CSR_ADDR, 32'h27);
    apb(1'h1, CSR_ADDR, 32'h37);
    rd(CSR_ADDR, 32'h27);
    chk(irq, 1'h0);
    $display("irq test done");
  endtask : test_irq

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // ****************************************
  // Clock, sequence, watchdog
  // ****************************************
  initial
  begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial
  begin
    {arst_n, psel, penable, pwrite, comp_raw, tmr, paddr, pwdata} = '0;
    tick(2);
    arst_n <= 1'h1;
    // Margin past the internal reset release
    tick(5);
    test_reset;
    test_rise;
    test_modes;
    test_timer;
    test_discard;
    test_irq;
    print_verdict;
  end

  // Whole run is about 740 cycles
  initial
  begin
    #60000;
    err_total++;
    print_verdict;
  end
endmodule : test_comparator_event_debounce
